// ===== bench/nva_access_ctrl_tb.sv
// Self-checking bench for the register-side control of the byte store.
// Assumes the CPU model drives the register bus; programmer and resets are driven here.
module nva_access_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import nva_pkg::*;

    // Short write time keeps the run small
    localparam int SC    = 20;
    localparam int LIMIT = 5000;
    logic       clk, rstn, master_clear_pin, dog, sleeping, brownout_detect, cprot, prd, pwr, sfr_wr, sfr_rd, busy;
    logic [6:0] paddr;
    logic [7:0] pwdata, prdata, addr, wdata, rdata, v;
    int         errors, cmp_count, cyc, n, t0;
    logic [7:0] regs [7] = '{8'h0c, 8'h8c, 8'h9a, 8'h9b, 8'h9c, 8'h9d, 8'h50};
    logic [7:0] k1s [5]  = '{8'h55, 8'h55, 8'h55, 8'haa, 8'h55};
    int         g1s [5]  = '{1, 3, 2, 2, 2};
    int         g2s [5]  = '{1, 1, 2, 1, 1};

    nva_access_ctrl #(.STORE_CYCLES(SC)) dut (
        .i_sys_clk(clk), .i_resetn(rstn), .i_sfr_addr(addr), .i_sfr_wr(sfr_wr),
        .i_sfr_wdata(wdata), .i_sfr_rd(sfr_rd), .o_sfr_rdata(rdata),
        .i_master_clear(master_clear_pin), .i_dog_timeout(dog), .i_sleeping(sleeping),
        .i_brownout_detect(brownout_detect), .i_code_protect(cprot), .i_prog_rd(prd),
        .i_prog_wr(pwr), .i_prog_addr(paddr), .i_prog_wdata(pwdata),
        .o_prog_rdata(prdata), .o_store_busy(busy));

    nva_cpu_model cpu (
        .i_sys_clk(clk), .i_sfr_rdata(rdata), .o_sfr_addr(addr), .o_sfr_wr(sfr_wr),
        .o_sfr_wdata(wdata), .o_sfr_rd(sfr_rd));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic summarize;
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            errors++;
            $display("mismatch at %0t: timeout", $time);
            summarize();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        cpu.rd(a, d);
        chk(d, exp, what);
    endtask

    // Bounded wait for the write strobe to drop
    task automatic wait_idle;
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk({7'h00, busy}, 8'h00, "write finished");
    endtask

    task automatic prog_wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk);
        paddr  = a;
        pwdata = d;
        pwr    = 1'b1;
        @(negedge clk);
        pwr = 1'b0;
    endtask

    task automatic prog_rd(input logic [6:0] a, output logic [7:0] d);
        @(negedge clk);
        paddr = a;
        prd   = 1'b1;
        @(negedge clk);
        prd = 1'b0;
        d   = prdata;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {rstn, master_clear_pin, dog, sleeping, brownout_detect, cprot, prd, pwr} = 8'h00;
        paddr  = 7'h00;
        pwdata = 8'h00;
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        foreach (regs[i]) rchk(regs[i], 8'h00, "reset value");
        cpu.wr(NVA_DATA_ADDR, 8'ha5);
        rchk(NVA_DATA_ADDR, 8'ha5, "data reg");
        cpu.wr(NVA_UNLOCK_ADDR, 8'hff);
        rchk(NVA_UNLOCK_ADDR, 8'h00, "unlock port");
        // Read bit left clear: location 0 has never been written
        cpu.wr(NVA_CTL_ADDR, 8'hfe);
        rchk(NVA_CTL_ADDR, 8'h0c, "control set");
        cpu.wr(NVA_CTL_ADDR, 8'h00);
        rchk(NVA_CTL_ADDR, 8'h00, "control clear");
        cpu.wr(NVA_IRQ_EN_ADDR, 8'hff);
        rchk(NVA_IRQ_EN_ADDR, 8'h80, "irq enable");
        prog_wr(7'h05, 8'h3c);
        prog_rd(7'h05, v);
        chk(v, 8'h3c, "programmer read");
        cprot = 1'b1;
        prog_wr(7'h05, 8'h99);
        prog_rd(7'h05, v);
        chk(v, 8'h00, "protected programmer read");
        cpu.wr(NVA_LOC_ADDR, 8'h05);
        cpu.wr(NVA_CTL_ADDR, 8'h01);
        rchk(NVA_DATA_ADDR, 8'h3c, "cpu read protected");
        rchk(NVA_CTL_ADDR, 8'h00, "read strobe");
        // Location bit 7 set on purpose: it must not reach the array
        cpu.wr(NVA_DATA_ADDR, 8'h5a);
        cpu.wr(NVA_LOC_ADDR, 8'h85);
        cpu.wr(NVA_CTL_ADDR, 8'h04);
        cpu.unlock(NVA_KEY_FIRST, NVA_KEY_SECOND, 2, 1, 8'h06);
        @(negedge clk);
        t0 = cyc;
        chk({7'h00, busy}, 8'h01, "busy after start");
        rchk(NVA_CTL_ADDR, 8'h06, "write strobe high");
        cpu.unlock(NVA_KEY_FIRST, NVA_KEY_SECOND, 2, 1, 8'h06);
        cpu.wr(NVA_CTL_ADDR, 8'h00);
        rchk(NVA_CTL_ADDR, 8'h02, "permit cleared mid-write");
        wait_idle();
        chk(8'((cyc - t0) > SC - 4 && (cyc - t0) < SC + 3), 8'h01, "write time");
        rchk(NVA_CTL_ADDR, 8'h00, "write done");
        rchk(NVA_IRQ_FLAGS_ADDR, 8'h80, "done flag");
        cpu.wr(NVA_IRQ_FLAGS_ADDR, 8'h00);
        rchk(NVA_IRQ_FLAGS_ADDR, 8'h00, "done flag cleared");
        cpu.wr(NVA_LOC_ADDR, 8'h05);
        cpu.wr(NVA_CTL_ADDR, 8'h01);
        rchk(NVA_DATA_ADDR, 8'h5a, "stored byte");
        // Wrong gaps, swapped keys, permit given with the strobe
        foreach (k1s[i]) begin
            cpu.wr(NVA_CTL_ADDR, (i == 4) ? 8'h00 : 8'h04);
            cpu.unlock(k1s[i], ~k1s[i], g1s[i], g2s[i], 8'h06);
            @(negedge clk);
            chk({7'h00, busy}, 8'h00, "refused start");
            rchk(NVA_CTL_ADDR, 8'h04, "refused strobe");
        end
        cpu.store_byte(7'h7f, 8'hc3);
        wait_idle();
        cpu.wr(NVA_LOC_ADDR, 8'h7f);
        cpu.wr(NVA_CTL_ADDR, 8'h01);
        rchk(NVA_DATA_ADDR, 8'hc3, "top location");
        // Warm resets: clear, timeout, brown-out, then timeout while asleep
        for (int i = 0; i < 4; i++) begin
            cpu.store_byte(7'h10, 8'h77);
            @(negedge clk);
            sleeping = (i == 3);
            master_clear_pin     = (i == 0);
            dog      = (i == 1 || i == 3);
            brownout_detect      = (i == 2);
            @(negedge clk);
            {master_clear_pin, dog, brownout_detect, sleeping} = 4'h0;
            if (i < 3) begin
                rchk(NVA_CTL_ADDR, 8'h08, "abort flag");
                rchk(NVA_DATA_ADDR, 8'h00, "data after abort");
                rchk(NVA_LOC_ADDR, 8'h00, "location after abort");
            end else begin
                chk({7'h00, busy}, 8'h01, "asleep timeout ignored");
                cpu.wr(NVA_CTL_ADDR, 8'h0c);
                wait_idle();
                rchk(NVA_CTL_ADDR, 8'h04, "abort cleared by write");
            end
        end
        cpu.wr(NVA_DATA_ADDR, 8'h11);
        chk(rdata, 8'h04, "read data held");
        summarize();
    end
endmodule

// ===== bench/nva_cpu_model.sv
// CPU-side model: issues register bus cycles to the byte store control.
// Assumes the design samples at rising edges; all changes here land on falling edges.
module nva_cpu_model (
    input  wire logic       i_sys_clk,
    input  wire logic [7:0] i_sfr_rdata,
    output logic      [7:0] o_sfr_addr,
    output logic            o_sfr_wr,
    output logic      [7:0] o_sfr_wdata,
    output logic            o_sfr_rd
);
    timeunit 1ns;
    timeprecision 1ps;
    import nva_pkg::*;

    initial begin
        o_sfr_addr  = 8'h00;
        o_sfr_wr    = 1'b0;
        o_sfr_wdata = 8'h00;
        o_sfr_rd    = 1'b0;
    end

    task automatic put(input logic [7:0] a, input logic [7:0] d);
        o_sfr_addr  = a;
        o_sfr_wdata = d;
        o_sfr_wr    = 1'b1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_sys_clk);
        put(a, d);
        @(negedge i_sys_clk);
        o_sfr_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_sys_clk);
        o_sfr_addr = a;
        o_sfr_rd   = 1'b1;
        @(negedge i_sys_clk);
        o_sfr_rd = 1'b0;
        @(negedge i_sys_clk);
        d = i_sfr_rdata;
    endtask

    // Gaps in instruction cycles; only 2 then 1 may start a write
    task automatic unlock(input logic [7:0] k1, input logic [7:0] k2, input int g1,
                          input int g2, input logic [7:0] ctl);
        @(negedge i_sys_clk);
        put(NVA_UNLOCK_ADDR, k1);
        repeat (g1 - 1) @(negedge i_sys_clk) o_sfr_wr = 1'b0;
        @(negedge i_sys_clk);
        put(NVA_UNLOCK_ADDR, k2);
        repeat (g2 - 1) @(negedge i_sys_clk) o_sfr_wr = 1'b0;
        @(negedge i_sys_clk);
        put(NVA_CTL_ADDR, ctl);
        @(negedge i_sys_clk);
        o_sfr_wr = 1'b0;
    endtask

    task automatic store_byte(input logic [6:0] loc, input logic [7:0] d);
        wr(NVA_DATA_ADDR, d);
        wr(NVA_LOC_ADDR, {1'b0, loc});
        wr(NVA_CTL_ADDR, 8'h04);
        unlock(NVA_KEY_FIRST, NVA_KEY_SECOND, 2, 1, 8'h06);
    endtask
endmodule

// ===== logic/nva_access_ctrl.sv
// Register-side control for the nonvolatile byte store.
// Assumes one bus write per instruction cycle; warm reset inputs are one-cycle pulses.
module nva_access_ctrl #(
    parameter int unsigned STORE_CYCLES = nva_pkg::NVA_STORE_TIME_US * nva_pkg::NVA_CLK_MHZ
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_resetn,
    input  wire logic [7:0] i_sfr_addr,
    input  wire logic       i_sfr_wr,
    input  wire logic [7:0] i_sfr_wdata,
    input  wire logic       i_sfr_rd,
    output logic      [7:0] o_sfr_rdata,
    input  wire logic       i_master_clear,
    input  wire logic       i_dog_timeout,
    input  wire logic       i_sleeping,
    input  wire logic       i_brownout_detect,
    input  wire logic       i_code_protect,
    input  wire logic       i_prog_rd,
    input  wire logic       i_prog_wr,
    input  wire logic [6:0] i_prog_addr,
    input  wire logic [7:0] i_prog_wdata,
    output logic      [7:0] o_prog_rdata,
    output logic            o_store_busy
);
    import nva_pkg::*;

    // ****************************************
    // State
    // ****************************************
    logic        done_flag_q, done_flag_d;
    logic        done_en_q, done_en_d;
    logic [7:0]  data_q, data_d;
    logic [7:0]  loc_q, loc_d;
    logic        rd_q, rd_d, wr_q, wr_d, permit_q, permit_d, abort_q, abort_d;
    nva_unlock_t unl_q, unl_d;
    logic [1:0]  gap_q, gap_d;
    logic [7:0]  rdata_q, rdata_d, prdata_q, prdata_d;

    logic        warm, wr_unl, wr_ctl, wr_start, st_done, st_busy;
    logic [7:0]  st_rdata, pr_data;
    logic [6:0]  rd_addr;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    // Dog timeout while asleep is a wake-up, not a reset
    assign warm     = i_master_clear | i_brownout_detect | (i_dog_timeout & ~i_sleeping);
    assign wr_unl   = i_sfr_wr && hit(i_sfr_addr, NVA_UNLOCK_ADDR);
    assign wr_ctl   = i_sfr_wr && hit(i_sfr_addr, NVA_CTL_ADDR);
    assign wr_start = !warm && wr_ctl && i_sfr_wdata[NVA_WR_BIT] && permit_q
                      && unl_q == NVA_UNL_GOT2 && !wr_q;
    // Programmer shares the read mux when it reads, even under protection; its read data is masked later
    assign rd_addr  = i_prog_rd ? i_prog_addr : loc_q[6:0];

    // ****************************************
    // Unlock sequence
    // ****************************************
    always_comb begin
        unl_d = unl_q;
        gap_d = gap_q + 2'h1;
        case (unl_q)
            NVA_UNL_IDLE: begin
                gap_d = 2'h0;
                if (wr_unl && i_sfr_wdata == NVA_KEY_FIRST) begin
                    unl_d = NVA_UNL_GOT1;
                end
            end
            NVA_UNL_GOT1: begin
                if (gap_q == NVA_GAP_KEYS - 2'h1) begin
                    unl_d = (wr_unl && i_sfr_wdata == NVA_KEY_SECOND)
                            ? NVA_UNL_GOT2 : NVA_UNL_IDLE;
                end else if (wr_unl) begin
                    unl_d = NVA_UNL_IDLE;
                end
            end
            NVA_UNL_GOT2: begin
                // Strobe must come on the very next cycle, else the key is lost
                unl_d = NVA_UNL_IDLE;
            end
            default: unl_d = NVA_UNL_IDLE;
        endcase
        if (warm) begin
            unl_d = NVA_UNL_IDLE;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            unl_q <= NVA_UNL_IDLE;
            gap_q <= 2'h0;
        end else begin
            unl_q <= unl_d;
            gap_q <= gap_d;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_comb begin
        done_flag_d = done_flag_q;
        done_en_d   = done_en_q;
        data_d      = data_q;
        loc_d       = loc_q;
        rd_d        = 1'b0;
        wr_d        = wr_q;
        permit_d    = permit_q;
        abort_d     = abort_q;
        if (i_sfr_wr) begin
            if (hit(i_sfr_addr, NVA_IRQ_FLAGS_ADDR)) begin
                done_flag_d = i_sfr_wdata[NVA_DONE_BIT];
            end
            if (hit(i_sfr_addr, NVA_IRQ_EN_ADDR)) begin
                done_en_d = i_sfr_wdata[NVA_DONE_BIT];
            end
            if (hit(i_sfr_addr, NVA_DATA_ADDR)) begin
                data_d = i_sfr_wdata;
            end
            if (hit(i_sfr_addr, NVA_LOC_ADDR)) begin
                loc_d = i_sfr_wdata;
            end
            if (wr_ctl) begin
                permit_d = i_sfr_wdata[NVA_PERMIT_BIT];
                abort_d  = i_sfr_wdata[NVA_ABORT_BIT];
                rd_d     = i_sfr_wdata[NVA_RD_BIT];
            end
        end
        if (rd_q) begin
            data_d = st_rdata;
        end
        if (wr_start) begin
            wr_d = 1'b1;
        end
        if (st_done) begin
            wr_d        = 1'b0;
            done_flag_d = 1'b1;
            abort_d     = 1'b0;
        end
        if (warm) begin
            if (wr_q) begin
                abort_d = 1'b1;
            end
            done_flag_d = NVA_REG_RESET[NVA_DONE_BIT];
            done_en_d   = NVA_REG_RESET[NVA_DONE_BIT];
            data_d      = NVA_REG_RESET;
            loc_d       = NVA_REG_RESET;
            rd_d        = 1'b0;
            wr_d        = 1'b0;
            permit_d    = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            done_flag_q <= 1'b0;
            done_en_q   <= 1'b0;
            data_q      <= NVA_REG_RESET;
            loc_q       <= NVA_REG_RESET;
            rd_q        <= 1'b0;
            wr_q        <= 1'b0;
            permit_q    <= 1'b0;
            abort_q     <= 1'b0;
        end else begin
            done_flag_q <= done_flag_d;
            done_en_q   <= done_en_d;
            data_q      <= data_d;
            loc_q       <= loc_d;
            rd_q        <= rd_d;
            wr_q        <= wr_d;
            permit_q    <= permit_d;
            abort_q     <= abort_d;
        end
    end

    // ****************************************
    // Read back
    // ****************************************
    always_comb begin
        rdata_d  = rdata_q;
        prdata_d = prdata_q;
        if (i_sfr_rd) begin
            case (i_sfr_addr)
                NVA_IRQ_FLAGS_ADDR: rdata_d = {done_flag_q, 7'h00};
                NVA_IRQ_EN_ADDR:    rdata_d = {done_en_q, 7'h00};
                NVA_DATA_ADDR:      rdata_d = data_q;
                NVA_LOC_ADDR:       rdata_d = loc_q;
                NVA_CTL_ADDR:       rdata_d = {4'h0, abort_q, permit_q, wr_q, rd_q};
                NVA_UNLOCK_ADDR:    rdata_d = 8'h00;
                default:            rdata_d = 8'h00;
            endcase
        end
        if (i_prog_rd) begin
            prdata_d = i_code_protect ? 8'h00 : st_rdata;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_q  <= 8'h00;
            prdata_q <= 8'h00;
        end else begin
            rdata_q  <= rdata_d;
            prdata_q <= prdata_d;
        end
    end

    assign o_sfr_rdata  = rdata_q;
    assign o_prog_rdata = prdata_q;
    assign o_store_busy = wr_q;
    assign pr_data      = i_prog_wdata;

    // ****************************************
    // Store
    // ****************************************
    // Permit only gates the start, so clearing it later cannot cut a write short
    nva_byte_store #(
        .STORE_CYCLES (STORE_CYCLES)
    ) u_store (
        .i_sys_clk   (i_sys_clk),
        .i_resetn    (i_resetn),
        .i_start     (wr_start),
        .i_abort     (warm),
        .i_wr_addr   (loc_q[6:0]),
        .i_wr_data   (data_q),
        .i_rd_addr   (rd_addr),
        .o_rd_data   (st_rdata),
        .i_prog_wr   (i_prog_wr && !i_code_protect),
        .i_prog_addr (i_prog_addr),
        .i_prog_data (pr_data),
        .o_busy      (st_busy),
        .o_done      (st_done)
    );

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_resetn);

    rd_one_cycle_a: assert property (rd_q |=> !rd_q)
        else $error("read strobe held past one cycle");
    rd_loads_data_a: assert property (rd_q && !warm |=> data_q == $past(st_rdata))
        else $error("read data not loaded next cycle");
    wr_needs_permit_a: assert property ($rose(wr_q) |-> $past(permit_q))
        else $error("write strobe set without permit");
    wr_needs_key_a: assert property ($rose(wr_q) |-> $past(unl_q) == NVA_UNL_GOT2)
        else $error("write began without unlock sequence");
    wr_tracks_store_a: assert property (wr_q && !warm |=> wr_q == st_busy)
        else $error("write strobe disagrees with store");
    done_sets_flag_a: assert property (st_done && !warm |=> done_flag_q && !wr_q)
        else $error("completion not flagged");
    abort_on_reset_a: assert property (warm && wr_q |=> abort_q && !wr_q)
        else $error("interrupted write not marked");
    warm_clears_regs_a: assert property (warm |=> loc_q == 8'h00 && data_q == 8'h00)
        else $error("warm reset left data or location");
    unlock_reads_zero_a: assert property (i_sfr_rd && i_sfr_addr == NVA_UNLOCK_ADDR
        |=> o_sfr_rdata == 8'h00)
        else $error("unlock port read nonzero");
    ctl_upper_zero_a: assert property (i_sfr_rd && i_sfr_addr == NVA_CTL_ADDR
        |=> o_sfr_rdata[7:4] == 4'h0)
        else $error("control upper bits nonzero");
    wr_no_restart_a: assert property (wr_q |-> !wr_start)
        else $error("write restarted while busy");

    // ****************************************
    // Sequence and strobe checks
    // ****************************************
    key_first_a: assert property (unl_q == NVA_UNL_GOT1 && $past(unl_q) == NVA_UNL_IDLE
        |-> $past(wr_unl) && $past(i_sfr_wdata) == NVA_KEY_FIRST)
        else $error("unlock armed without first key");
    key_second_a: assert property (unl_q == NVA_UNL_GOT2
        |-> $past(wr_unl) && $past(i_sfr_wdata) == NVA_KEY_SECOND)
        else $error("unlock completed without second key");
    key_gap_a: assert property (unl_q == NVA_UNL_GOT2
        |-> $past(unl_q) == NVA_UNL_GOT1 && $past(unl_q, 2) == NVA_UNL_GOT1
            && $past(unl_q, 3) == NVA_UNL_IDLE)
        else $error("second key not two cycles after first");
    key_lapses_a: assert property (unl_q == NVA_UNL_GOT2 |=> unl_q == NVA_UNL_IDLE)
        else $error("unlock held past strobe cycle");
    rd_starts_a: assert property (wr_ctl && i_sfr_wdata[NVA_RD_BIT] && !warm |=> rd_q)
        else $error("read strobe not set by software");
    wr_sw_keeps_a: assert property (wr_q && !st_done && !warm |=> wr_q)
        else $error("write strobe cleared before completion");
    permit_drop_a: assert property (wr_q && wr_ctl && !i_sfr_wdata[NVA_PERMIT_BIT]
        && !st_done && !warm |=> wr_q && st_busy)
        else $error("clearing permit cut the write short");
    loc_low_bits_a: assert property (wr_start |=> u_store.addr_q == $past(loc_q[6:0]))
        else $error("store address not from low location bits");
    abort_done_clear_a: assert property (st_done && !warm |=> !abort_q)
        else $error("abort flag left after completed write");
    sleep_no_abort_a: assert property (i_dog_timeout && i_sleeping && !i_master_clear
        && !i_brownout_detect && wr_q && !st_done |=> wr_q)
        else $error("timeout while asleep cut the write");
    warm_permit_a: assert property (warm |=> !permit_q && !wr_q && !rd_q)
        else $error("warm reset left permit or strobes");
    prog_blocked_a: assert property (i_prog_rd && i_code_protect |=> o_prog_rdata == 8'h00)
        else $error("programmer read through protection");
    flag_sw_clear_a: assert property (i_sfr_wr && i_sfr_addr == NVA_IRQ_FLAGS_ADDR
        && !i_sfr_wdata[NVA_DONE_BIT] && !st_done |=> !done_flag_q)
        else $error("done flag not cleared by software");
    data_sw_write_a: assert property (i_sfr_wr && i_sfr_addr == NVA_DATA_ADDR
        && !rd_q && !warm |=> data_q == $past(i_sfr_wdata))
        else $error("software write to data register lost");
    ctl_wr_view_a: assert property (i_sfr_rd && i_sfr_addr == NVA_CTL_ADDR
        |=> o_sfr_rdata[NVA_WR_BIT] == $past(wr_q))
        else $error("write strobe not shown in control");
endmodule

// ===== logic/nva_byte_store.sv
// Byte store: flip-flop array with timed erase-then-program write.
// Assumes start is a pulse only when idle; abort cancels a write in flight.
module nva_byte_store #(
    parameter int unsigned STORE_CYCLES = 125000
) (
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_resetn,
    input  wire logic                      i_start,
    input  wire logic                      i_abort,
    input  wire logic [nva_pkg::NVA_AW-1:0] i_wr_addr,
    input  wire logic [7:0]                i_wr_data,
    input  wire logic [nva_pkg::NVA_AW-1:0] i_rd_addr,
    output logic      [7:0]                o_rd_data,
    input  wire logic                      i_prog_wr,
    input  wire logic [nva_pkg::NVA_AW-1:0] i_prog_addr,
    input  wire logic [7:0]                i_prog_data,
    output logic                           o_busy,
    output logic                           o_done
);
    import nva_pkg::*;

    localparam logic [31:0] HALF = 32'(STORE_CYCLES / 2);

    // No reset on the array: contents survive every reset
    logic [7:0]        mem [NVA_DEPTH];
    logic              busy_q, busy_d, prog_q, prog_d, done_d;
    logic [31:0]       cnt_q, cnt_d;
    logic [NVA_AW-1:0] addr_q, addr_d;
    logic [7:0]        data_q, data_d;
    logic              mem_we;
    logic [NVA_AW-1:0] mem_a;
    logic [7:0]        mem_v;

    always_comb begin
        busy_d = busy_q;
        prog_d = prog_q;
        done_d = 1'b0;
        cnt_d  = cnt_q;
        addr_d = addr_q;
        data_d = data_q;
        mem_we = 1'b0;
        mem_a  = addr_q;
        mem_v  = data_q;
        if (i_abort) begin
            busy_d = 1'b0;
            prog_d = 1'b0;
        end else if (i_start && !busy_q) begin
            busy_d = 1'b1;
            prog_d = 1'b0;
            cnt_d  = 32'h0;
            addr_d = i_wr_addr;
            data_d = i_wr_data;
        end else if (busy_q) begin
            if (cnt_q == HALF - 32'h1) begin
                cnt_d  = 32'h0;
                mem_we = 1'b1;
                if (!prog_q) begin
                    mem_v  = NVA_ERASED;
                    prog_d = 1'b1;
                end else begin
                    busy_d = 1'b0;
                    prog_d = 1'b0;
                    done_d = 1'b1;
                end
            end else begin
                cnt_d = cnt_q + 32'h1;
            end
        end else if (i_prog_wr) begin
            mem_we = 1'b1;
            mem_a  = i_prog_addr;
            mem_v  = i_prog_data;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            busy_q <= 1'b0;
            prog_q <= 1'b0;
            cnt_q  <= 32'h0;
            addr_q <= '0;
            data_q <= 8'h00;
        end else begin
            busy_q <= busy_d;
            prog_q <= prog_d;
            cnt_q  <= cnt_d;
            addr_q <= addr_d;
            data_q <= data_d;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (mem_we) begin
            mem[mem_a] <= mem_v;
        end
    end

    assign o_rd_data = mem[i_rd_addr];
    assign o_busy    = busy_q;
    // Completion is combinational so the write strobe drops together with busy
    assign o_done    = done_d;
endmodule

// ===== logic/nva_pkg.sv
// Constants for the nonvolatile byte store access logic.
// Assumes one 25 MHz clock; each bus write stands for one CPU instruction cycle.
//
// Function
// - 128 bytes, locations 0 to 127
// - Byte write erases, then programs
// - Internal timer sets write time; hardware signals completion
// - Protection blocks programmer, not CPU
// - Location bit 7 ignored for addressing
// - Control bits 7-4 read zero
// - Strobes set-only; hardware clears them
// - Read strobe completes in one cycle
// - Write needs permit bit; permit clear at power-up
// - Abort flag marks interrupted write
// - Warm reset clears data and location
// - Done flag set; software clears it
// - Unlock port unstored, reads zero
// - Write strobe high while writing
// - Exact 55h, AAh, strobe sequence starts write
// - Read data next cycle, held
// - Write strobe needs permit already set
// - Clearing permit never aborts write
package nva_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] NVA_IRQ_FLAGS_ADDR = 8'h0c;
    localparam logic [7:0] NVA_IRQ_EN_ADDR    = 8'h8c;
    localparam logic [7:0] NVA_DATA_ADDR      = 8'h9a;
    localparam logic [7:0] NVA_LOC_ADDR       = 8'h9b;
    localparam logic [7:0] NVA_CTL_ADDR       = 8'h9c;
    localparam logic [7:0] NVA_UNLOCK_ADDR    = 8'h9d;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int         NVA_DONE_BIT   = 7;
    localparam int         NVA_RD_BIT     = 0;
    localparam int         NVA_WR_BIT     = 1;
    localparam int         NVA_PERMIT_BIT = 2;
    localparam int         NVA_ABORT_BIT  = 3;
    localparam logic [7:0] NVA_REG_RESET  = 8'h00;
    localparam logic [7:0] NVA_ERASED     = 8'hff;
    localparam int         NVA_DEPTH      = 128;
    localparam int         NVA_AW         = 7;

    // ****************************************
    // Unlock sequence
    // ****************************************
    localparam logic [7:0] NVA_KEY_FIRST  = 8'h55;
    localparam logic [7:0] NVA_KEY_SECOND = 8'haa;
    localparam logic [1:0] NVA_GAP_KEYS   = 2'h2;

    typedef enum logic [2:0] {
        NVA_UNL_IDLE  = 3'b001,
        NVA_UNL_GOT1  = 3'b010,
        NVA_UNL_GOT2  = 3'b100
    } nva_unlock_t;

    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned NVA_CLK_MHZ       = 25;
    localparam int unsigned NVA_STORE_TIME_US = 5000;
endpackage
